// [hw/nvm_pkg.sv]
// Shared constants and types for the user nonvolatile byte read port.
package nvm_pkg;

	localparam int unsigned NVM_BANKS      = 8;
	localparam int unsigned BANK_BITS      = 128;
	localparam int unsigned BYTE_W         = 8;
	localparam int unsigned BYTES_PER_BANK = BANK_BITS / BYTE_W;
	localparam int unsigned NVM_BYTES      = NVM_BANKS * BYTES_PER_BANK;
	localparam int unsigned ADDR_W         = 7;
	localparam int unsigned BANK_FIELD_W   = 3;
	localparam int unsigned BYTE_FIELD_W   = 4;
	localparam int unsigned BANK_FIELD_LSB = 4;
	localparam int unsigned KEY_W          = 128;

	localparam logic [BYTE_W-1:0]    ERASED_BYTE = 8'hFF;
	localparam logic [BYTE_W-1:0]    ZERO_BYTE   = 8'h00;
	localparam logic [ADDR_W-1:0]    ZERO_ADDR   = 7'h00;
	localparam logic [NVM_BANKS-1:0] BLANK_RST   = 8'h00;

	typedef logic [ADDR_W-1:0]       nvm_addr_t;
	typedef logic [BYTE_W-1:0]       nvm_byte_t;
	typedef logic [BANK_FIELD_W-1:0] bank_sel_t;
	typedef logic [BYTE_FIELD_W-1:0] byte_sel_t;

	typedef enum logic [1:0] {
		CMD_NOP   = 2'b00,
		CMD_WRITE = 2'b01,
		CMD_ERASE = 2'b10,
		CMD_READ  = 2'b11
	} prog_cmd_t;

endpackage : nvm_pkg

// [hw/prog_xfer_if.sv]
// Carrier between the storage core and the programming data decrypt stage.
`timescale 1ns/1ns
interface prog_xfer_if;
	import nvm_pkg::*;

	logic      in_valid;
	logic      in_decrypt;
	nvm_addr_t in_addr;
	nvm_byte_t in_data;
	logic      out_valid;
	nvm_addr_t out_addr;
	nvm_byte_t out_data;

	modport src (
		output in_valid,
		output in_decrypt,
		output in_addr,
		output in_data,
		input  out_valid,
		input  out_addr,
		input  out_data
	);

	modport dst (
		input  in_valid,
		input  in_decrypt,
		input  in_addr,
		input  in_data,
		output out_valid,
		output out_addr,
		output out_data
	);

endinterface : prog_xfer_if

// [hw/prog_decrypt.sv]
// One-cycle decrypt stage for incoming programming bytes.
`timescale 1ns/1ns
module prog_decrypt
	import nvm_pkg::*;
#(
	parameter bit HAS_DECRYPT = 1'b1
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic [KEY_W-1:0] decrypt_key,
	prog_xfer_if.dst              xfer
);

	nvm_byte_t key_byte;
	nvm_byte_t plain;

	// The keystream is a stand-in cipher: a key byte picked by the byte
	// index and whitened with the address. It keeps the path and timing of
	// a real engine so that a stronger core can be dropped in later.
	always_comb begin
		key_byte = decrypt_key[{xfer.in_addr[BYTE_FIELD_W-1:0], 3'h0} +: BYTE_W];
		if (HAS_DECRYPT && xfer.in_decrypt) begin
			plain = xfer.in_data ^ key_byte ^ {1'b0, xfer.in_addr};
		end else begin
			plain = xfer.in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			xfer.out_valid <= 1'b0;
		end else if (ce) begin
			xfer.out_valid <= xfer.in_valid;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			xfer.out_addr <= ZERO_ADDR;
			xfer.out_data <= ZERO_BYTE;
		end else if (ce && xfer.in_valid) begin
			xfer.out_addr <= xfer.in_addr;
			xfer.out_data <= plain;
		end
	end

endmodule : prog_decrypt

// [hw/user_nvm_byte_read_port.sv]
// User nonvolatile memory with a core byte read port and a programming port.
// What this block does
// - Storage is eight banks of 128 bits.
// - Core reads one byte per access, synchronously.
// - Seven-bit address selects bank and byte.
// - Upper three address bits pick the bank.
// - Lower four address bits pick the byte.
// - Erase and write only via programming port.
// - Contents readable via programming port and core.
// - Optional on-chip decryption of programming data.
// - Contents survive reset and power loss.
`timescale 1ns/1ns
module user_nvm_byte_read_port
	import nvm_pkg::*;
#(
	parameter bit HAS_DECRYPT = 1'b1
) (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	// Core side read port.
	input  wire logic                 rd_en,
	input  wire logic [ADDR_W-1:0]    rd_addr,
	output logic      [BYTE_W-1:0]    rd_data,
	output logic                      rd_valid,
	// Programming port.
	input  wire logic                 prog_valid,
	output logic                      prog_ready,
	input  wire logic [1:0]           prog_cmd,
	input  wire logic [ADDR_W-1:0]    prog_addr,
	input  wire logic [BYTE_W-1:0]    prog_wdata,
	input  wire logic                 prog_decrypt,
	input  wire logic [KEY_W-1:0]     decrypt_key,
	output logic      [BYTE_W-1:0]    prog_rdata,
	output logic                      prog_rvalid,
	output logic                      prog_done,
	output logic                      prog_error,
	output logic      [NVM_BANKS-1:0] bank_blank
);

	// Flash array: never touched by reset, so contents outlive any reset
	// of the surrounding logic.
	nvm_byte_t mem [NVM_BYTES];

	nvm_byte_t             rd_data_q;
	logic                  rd_valid_q;
	nvm_byte_t             prog_rdata_q;
	logic                  prog_rvalid_q;
	logic                  prog_done_q;
	logic                  prog_error_q;
	logic [NVM_BANKS-1:0]  bank_blank_q;
	// Next values of the output registers.
	nvm_byte_t             rd_data_d;
	nvm_byte_t             prog_rdata_d;
	logic [NVM_BANKS-1:0]  bank_blank_d;

	prog_cmd_t cmd;
	logic      take;
	logic      take_write;
	logic      take_erase;
	logic      take_read;
	logic      bad_decrypt;
	logic      take_bad;
	bank_sel_t rd_bank;
	byte_sel_t rd_byte;
	bank_sel_t pg_bank;
	bank_sel_t wr_bank;

	prog_xfer_if xfer ();

	prog_decrypt #(
		.HAS_DECRYPT (HAS_DECRYPT)
	) u_decrypt (
		.clk_sys     (clk_sys),
		.nrst        (nrst),
		.ce          (ce),
		.decrypt_key (decrypt_key),
		.xfer        (xfer)
	);

	// Address split for the core read port.
	assign rd_bank = rd_addr[BANK_FIELD_LSB +: BANK_FIELD_W];
	assign rd_byte = rd_addr[BYTE_FIELD_W-1:0];

	// Address split for the programming port.
	assign pg_bank = prog_addr[BANK_FIELD_LSB +: BANK_FIELD_W];
	assign wr_bank = xfer.out_addr[BANK_FIELD_LSB +: BANK_FIELD_W];

	// A write in the decrypt stage holds the port off for one cycle. That
	// keeps every command in issue order without any hazard checking.
	assign prog_ready = ~xfer.out_valid;

	// Command codes: a nop is ignored, a write goes through the decrypt
	// stage, an erase fills one bank with the erased value in one edge,
	// and a read answers at the edge that takes it. Every code is legal,
	// so the cast below can never produce an unknown command.
	assign cmd  = prog_cmd_t'(prog_cmd);
	assign take = ce & prog_valid & prog_ready;

	// Decryption asked for on a variant without the engine is refused
	// rather than silently storing cipher text.
	assign bad_decrypt = prog_decrypt & ~HAS_DECRYPT;

	assign take_write = take & (cmd == CMD_WRITE) & ~bad_decrypt;
	assign take_erase = take & (cmd == CMD_ERASE);
	assign take_read  = take & (cmd == CMD_READ);

	// A refused write still counts as taken, so the port never stalls on
	// it and the caller sees the refusal one edge later.
	assign take_bad   = take & (cmd == CMD_WRITE) & bad_decrypt;

	assign xfer.in_valid   = take_write;
	assign xfer.in_decrypt = prog_decrypt;
	assign xfer.in_addr    = prog_addr;
	assign xfer.in_data    = prog_wdata;

	// Both read ports look the array up before the edge, so a read taken
	// in the edge that stores a byte returns the byte as it was.
	assign rd_data_d    = mem[{rd_bank, rd_byte}];
	assign prog_rdata_d = mem[prog_addr];

	// The only paths that change the array come from the programming
	// port; the core side has no write input at all.
	// The clock enable gates the array too: with it low nothing is stored,
	// which keeps a frozen block exactly where it stood.
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			if (take_erase) begin
				for (int i = 0; i < BYTES_PER_BANK; i++) begin
					mem[{pg_bank, byte_sel_t'(i)}] <= ERASED_BYTE;
				end
			end
			if (xfer.out_valid) begin
				mem[xfer.out_addr] <= xfer.out_data;
			end
		end
	end

	// Core read: address taken at the edge, byte shown after it and held
	// until the next accepted read.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= ZERO_BYTE;
		end else if (ce && rd_en) begin
			rd_data_q <= rd_data_d;
		end
	end

	// Valid follows the enable at every running edge, so it marks each
	// accepted read until the next running edge.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_valid_q <= 1'b0;
		end else if (ce) begin
			rd_valid_q <= rd_en;
		end
	end

	// Readback through the programming port.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prog_rdata_q <= ZERO_BYTE;
		end else if (take_read) begin
			prog_rdata_q <= prog_rdata_d;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prog_rvalid_q <= 1'b0;
		end else if (ce) begin
			prog_rvalid_q <= take_read;
		end
	end

	// Completion and refusal strobes for the programming port.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prog_done_q <= 1'b0;
		end else if (ce) begin
			prog_done_q <= take_erase | xfer.out_valid;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prog_error_q <= 1'b0;
		end else if (ce) begin
			prog_error_q <= take_bad;
		end
	end

	// Blank tracking per bank. It is volatile and clears at reset, so it
	// only reports erases seen since then. A stored write wins over an
	// erase of the same bank in one edge.
	always_comb begin
		bank_blank_d = bank_blank_q;
		for (int b = 0; b < NVM_BANKS; b++) begin
			if (xfer.out_valid && wr_bank == bank_sel_t'(b)) begin
				bank_blank_d[b] = 1'b0;
			end else if (take_erase && pg_bank == bank_sel_t'(b)) begin
				bank_blank_d[b] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bank_blank_q <= BLANK_RST;
		end else if (ce) begin
			bank_blank_q <= bank_blank_d;
		end
	end

	assign rd_data     = rd_data_q;
	assign rd_valid    = rd_valid_q;
	assign prog_rdata  = prog_rdata_q;
	assign prog_rvalid = prog_rvalid_q;
	assign prog_done   = prog_done_q;
	assign prog_error  = prog_error_q;
	assign bank_blank  = bank_blank_q;

endmodule : user_nvm_byte_read_port

// [bench/nvm_port_sva.sv]
// Property checker for the nonvolatile byte read port.
`timescale 1ns/1ns
module nvm_port_sva
	import nvm_pkg::*;
#(
	parameter bit HAS_DECRYPT = 1'b1
) (
	input wire logic                 clk_sys,
	input wire logic                 nrst,
	input wire logic                 ce,
	input wire logic                 rd_en,
	input wire logic [BYTE_W-1:0]    rd_data,
	input wire logic                 rd_valid,
	input wire logic                 prog_valid,
	input wire logic                 prog_ready,
	input wire logic [1:0]           prog_cmd,
	input wire logic [ADDR_W-1:0]    prog_addr,
	input wire logic                 prog_decrypt,
	input wire logic                 prog_rvalid,
	input wire logic                 prog_done,
	input wire logic                 prog_error,
	input wire logic [NVM_BANKS-1:0] bank_blank
);
	logic take;
	logic wr;
	assign take = ce && prog_valid && prog_ready;
	assign wr = take && prog_cmd == 2'b01 && (HAS_DECRYPT || !prog_decrypt);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	rd_valid_a: assert property (ce && rd_en |=> rd_valid)
		else $error("read not answered");
	rd_idle_a: assert property (ce && !rd_en |=> !rd_valid)
		else $error("stray read valid");
	rd_hold_a: assert property (!(ce && rd_en) |=> $stable(rd_data))
		else $error("read byte moved");
	wr_busy_a: assert property (wr |=> !prog_ready)
		else $error("write not held");
	wr_done_a: assert property (wr ##1 ce |=> prog_done && prog_ready)
		else $error("write not stored");
	er_done_a: assert property (take && prog_cmd == 2'b10 |=>
		prog_done && bank_blank[$past(prog_addr[6:4])]) else $error("erase");
	rb_valid_a: assert property (take && prog_cmd == 2'b11 |=> prog_rvalid)
		else $error("readback missing");
	no_err_a: assert property (ce && !(take && prog_cmd == 2'b01 &&
		prog_decrypt && !HAS_DECRYPT) |=> !prog_error)
		else $error("stray write refusal");
	err_set_a: assert property (take && prog_cmd == 2'b01 &&
		prog_decrypt && !HAS_DECRYPT |=> prog_error)
		else $error("decrypt write not refused");
	cover property (ce && rd_en ##1 ce && rd_en);
	cover property (wr ##2 take);
	cover property (take && prog_cmd == 2'b10);
endmodule : nvm_port_sva
bind user_nvm_byte_read_port nvm_port_sva #(.HAS_DECRYPT(HAS_DECRYPT)) u_sva (
	.clk_sys, .nrst, .ce, .rd_en, .rd_data, .rd_valid, .prog_valid,
	.prog_ready, .prog_cmd, .prog_addr, .prog_decrypt, .prog_rvalid,
	.prog_done, .prog_error, .bank_blank);

// [bench/core_reader.sv]
// Core-side user logic model that issues byte reads.
`timescale 1ns/1ns
module core_reader
	import nvm_pkg::*;
(
	input  wire logic      clk_sys,
	input  wire logic      go,
	input  wire nvm_addr_t addr,
	output logic           rd_en,
	output nvm_addr_t      rd_addr
);
	nvm_addr_t idle_q;
	// An idle address toggles so a stale value never looks like a request.
	always_ff @(posedge clk_sys) begin
		idle_q <= ~rd_addr;
	end
	assign rd_en   = go;
	assign rd_addr = go ? addr : idle_q;
endmodule : core_reader

// [bench/user_nvm_byte_read_port_tb.sv]
// Self-checking bench for the nonvolatile byte read port.
`timescale 1ns/1ns
module user_nvm_byte_read_port_tb;
	import nvm_pkg::*;
	logic                 clk_sys, nrst, ce, go, rd_en, rd_valid;
	logic                 prog_valid, prog_decrypt, prog_ready;
	logic                 prog_rvalid, prog_done, prog_error;
	logic [1:0]           prog_cmd;
	logic [KEY_W-1:0]     key;
	logic [NVM_BANKS-1:0] bank_blank, blank;
	nvm_addr_t            addr, rd_addr, prog_addr, a;
	nvm_byte_t            rd_data, prog_wdata, prog_rdata;
	nvm_byte_t            mem [NVM_BYTES];
	int                   num_errors, n_compared, seed;
	user_nvm_byte_read_port u_dut (.clk_sys, .nrst, .ce, .rd_en, .rd_addr,
		.rd_data, .rd_valid, .prog_valid, .prog_ready, .prog_cmd, .prog_addr,
		.prog_wdata, .prog_decrypt, .decrypt_key(key), .prog_rdata,
		.prog_rvalid, .prog_done, .prog_error, .bank_blank);
	core_reader u_core (.clk_sys, .go, .addr, .rd_en, .rd_addr);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic chk_byte(input string what, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk_byte
	task automatic chk_flag(input string what, input logic e, g);
		chk_byte(what, {7'h00, e}, {7'h00, g});
	endtask : chk_flag
	// Valid stays up between commands; a write is never retaken while busy.
	task automatic prog(input logic [1:0] c, input nvm_addr_t pa,
			input nvm_byte_t pd);
		prog_valid = 1'b1;
		prog_cmd = c;
		prog_addr = pa;
		prog_wdata = pd;
		prog_decrypt = pd[0];
		if (c == 2'b01) begin
			mem[pa] = pd[0] ? pd ^ key[8*pa[3:0] +: 8] ^ {1'b0, pa} : pd;
			blank[pa[6:4]] = 1'b0;
		end else if (c == 2'b10) begin
			blank[pa[6:4]] = 1'b1;
			for (int i = 0; i < 16; i++) mem[{pa[6:4], 4'(i)}] = 8'hFF;
		end
		@(negedge clk_sys);
		if (c == 2'b01) begin
			chk_flag("prog_ready", 1'b0, prog_ready);
			@(negedge clk_sys);
		end
		chk_flag("prog_done", c == 2'b01 || c == 2'b10, prog_done);
		chk_flag("prog_error", 1'b0, prog_error);
		chk_flag("prog_ready", 1'b1, prog_ready);
		chk_flag("prog_rvalid", c == 2'b11, prog_rvalid);
		if (c == 2'b11) chk_byte("prog_rdata", mem[pa], prog_rdata);
	endtask : prog
	task automatic core_rd(input nvm_addr_t ra);
		go = 1'b1;
		addr = ra;
		@(negedge clk_sys);
		chk_flag("rd_valid", 1'b1, rd_valid);
		chk_byte("rd_data", mem[ra], rd_data);
	endtask : core_rd
	task automatic complete_run;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		complete_run();
	end
	initial begin
		seed = 32'h12AA;
		{nrst, go, prog_valid, prog_decrypt, ce} = 5'b00001;
		{addr, prog_cmd, prog_addr, prog_wdata, blank} = '0;
		key = {$random(seed), $random(seed), $random(seed), $random(seed)};
		repeat (4) @(negedge clk_sys);
		nrst = 1'b1;
		for (int b = 0; b < 8; b++) prog(2'b10, 7'(b * 16), 8'h00);
		chk_byte("bank_blank", blank, bank_blank);
		repeat (60) prog(2'b01, 7'($random(seed)), 8'($random(seed)));
		prog_valid = 1'b0;
		chk_byte("bank_blank", blank, bank_blank);
		for (int i = 0; i < 128; i++) core_rd(7'(i));
		ce = 1'b0;
		addr = 7'h05;
		@(negedge clk_sys);
		chk_byte("rd_data", mem[127], rd_data);
		chk_flag("rd_valid", 1'b1, rd_valid);
		ce = 1'b1;
		go = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk_byte("rd_data", mem[127], rd_data);
		chk_flag("rd_valid", 1'b0, rd_valid);
		repeat (8) prog(2'b11, 7'($random(seed)), 8'h00);
		prog(2'b00, 7'($random(seed)), 8'($random(seed)));
		chk_byte("bank_blank", blank, bank_blank);
		prog_valid = 1'b0;
		a = 7'($random(seed));
		nrst = 1'b0;
		blank = '0;
		@(negedge clk_sys);
		chk_byte("bank_blank", blank, bank_blank);
		nrst = 1'b1;
		core_rd(a);
		go = 1'b0;
		complete_run();
	end
endmodule : user_nvm_byte_read_port_tb
